//--- common/sadc_defs.vh
// Constants for the serial readout block of the 12-bit converter.
// Assumes inclusion by every design file that needs frame timing or codes.
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH
`define SADC_FRAME_LEN   5'd16
`define SADC_LEAD_ZEROS  5'd4
`define SADC_ACQ_CYCLES  5'd3
`define SADC_RES_BITS    4'd12
`define SADC_CNT_W       5
`define SADC_POS_FULL    12'h7ff
`define SADC_NEG_FULL    12'h800
`define SADC_MID_CODE    12'h000
`endif

//--- rtl/sadc_sample_hold.v
// Sample store: holds the captured input code for one conversion.
// Assumes the caller pulses the capture strobe once per conversion start.
`timescale 1ns/1ns
`include "sadc_defs.vh"
module sadc_sample_hold (
  core_clk,
  sys_rst,
  capture,
  din,
  dout
);
  input  wire        core_clk;
  input  wire        sys_rst;
  input  wire        capture;
  input  wire [11:0] din;
  output reg  [11:0] dout;

  // The array is disconnected from the input except in the capture cycle.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dout <= `SADC_MID_CODE;
    end else if (capture) begin
      dout <= din;
    end
  end
endmodule // sadc_sample_hold

//--- rtl/sadc_serial_readout.v
// Conversion sequencer and serial result readout of a 12-bit differential converter.
// Assumes frame select and serial clock come from a host, asynchronous to core_clk.
// How it works
// RQ1: One conversion and one readout frame take exactly sixteen serial clock cycles.
// RQ2: Host may raise frame select early when fewer than twelve bits are needed.
// RQ3: Result leaves serially on the data output, most significant bit first.
// RQ4: Each output bit is decided during the current conversion, not from an old result.
// RQ5: With frame select still low after a conversion, the next starts at once.
// RQ6: Host captures each output bit on the serial clock rising edge.
// RQ7: Acquisition lasts three serial clock cycles from frame select falling.
// RQ8: Input is sampled at conversion start and disconnected while converting.
// RQ9: Result is 12-bit two's complement, 7ff positive and 800 negative full scale.
// RQ10: First four falling edges shift zeros, next twelve shift result bits.
// RQ11: Output floats and the converter powers down while frame select is high.
// RQ12: Output takes each new bit on the serial clock falling edge.
// RQ13: Frame select rising before edge sixteen aborts; next fall starts anew.
// RQ14: Host counts cycles modulo sixteen to delimit results and drop zeros.
// RQ15: Host treats the first result bit as the sign of the value.
`timescale 1ns/1ns
`include "sadc_defs.vh"
module sadc_serial_readout (
  core_clk,
  sys_rst,
  frame_sel_n,
  sclk,
  ain_code,
  dout_o,
  dout_oe,
  power_down,
  acquiring,
  conv_done
);
  input  wire        core_clk;
  input  wire        sys_rst;
  input  wire        frame_sel_n;
  input  wire        sclk;
  input  wire [11:0] ain_code;
  output reg         dout_o;
  output reg         dout_oe;
  output reg         power_down;
  output reg         acquiring;
  output reg         conv_done;

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg        fs_meta_r;
  reg        fs_sync_r;
  reg        ck_meta_r;
  reg        ck_sync_r;
  reg        ck_prev_r;
  reg        st_r;
  reg        st_nxt;
  reg  [`SADC_CNT_W-1:0] fall_cnt_r;
  reg  [`SADC_CNT_W-1:0] fall_cnt_nxt;
  reg  [11:0] sar_r;
  reg  [11:0] sar_nxt;
  reg        cap_r;
  reg        cap_nxt;
  reg        bit_nxt;
  reg        done_nxt;
  wire [11:0] held_code;
  wire       sclk_fall;
  wire       frame_on;
  wire       frame_wrap;
  wire       lead_phase;
  wire       tap_bit;
  wire [11:0] tap_hit;
  wire [15:0] tap_onehot;
  wire [`SADC_CNT_W-1:0] tap_pos;
  wire [`SADC_CNT_W-1:0] start_cnt;
  reg        oe_nxt;
  reg        pd_nxt;
  reg        acq_nxt;

  // Both pins are foreign to core_clk, so each passes two flops first.
  // Frame select idles high, so its flops reset high and no frame appears out of reset.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fs_meta_r <= 1'b1;
      fs_sync_r <= 1'b1;
    end else begin
      fs_meta_r <= frame_sel_n;
      fs_sync_r <= fs_meta_r;
    end
  end

  // Only the second and third flops feed edge detection; the first may still be settling.
  // A low reset value can only yield a rising edge, which nothing here acts on.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ck_meta_r <= 1'b0;
      ck_sync_r <= 1'b0;
      ck_prev_r <= 1'b0;
    end else begin
      ck_meta_r <= sclk;
      ck_sync_r <= ck_meta_r;
      ck_prev_r <= ck_sync_r;
    end
  end

  assign sclk_fall = ck_prev_r & ~ck_sync_r;
  assign frame_on  = ~fs_sync_r;

  // Position decode shared by the sequencer and the status outputs.
  assign frame_wrap = (fall_cnt_r == `SADC_FRAME_LEN); // [RQ1]
  assign lead_phase = (fall_cnt_nxt < `SADC_LEAD_ZEROS); // [RQ7]
  // A frame select that falls while the clock is low stands in for the first falling edge.
  assign start_cnt  = ck_sync_r ? {`SADC_CNT_W{1'b0}} : {{(`SADC_CNT_W-1){1'b0}}, 1'b1};

  // Tap of the bit that the next falling edge emits; counts outside the result
  // window shift the one-hot word out of range, so no tap is selected there.
  assign tap_pos    = (`SADC_FRAME_LEN - {{(`SADC_CNT_W-1){1'b0}}, 1'b1}) - fall_cnt_r;
  assign tap_onehot = 16'h0001 << tap_pos;

  // One gate per result bit. Only the sample captured for this conversion feeds
  // the taps, so no bit of an earlier result can reach the line. [RQ4]
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi = gi + 1) begin : g_tap
      assign tap_hit[gi] = tap_onehot[gi] & held_code[gi]; // [RQ3]
    end
  endgenerate
  assign tap_bit = |tap_hit;

  sadc_sample_hold u_hold (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .capture  (cap_r),
    .din      (ain_code),
    .dout     (held_code)
  );

  // A frame select that falls while the clock is low counts as the first falling edge,
  // so the count starts at one; otherwise the first real falling edge makes it one.
  always @* begin
    st_nxt       = st_r;
    fall_cnt_nxt = fall_cnt_r;
    sar_nxt      = sar_r;
    cap_nxt      = 1'b0;
    bit_nxt      = dout_o;
    done_nxt     = 1'b0;
    case (st_r)
      ST_IDLE: begin
        bit_nxt = 1'b0;
        if (frame_on) begin
          st_nxt       = ST_RUN;
          sar_nxt      = 12'h000;
          fall_cnt_nxt = start_cnt; // [RQ7]
        end
      end
      ST_RUN: begin
        if (!frame_on) begin
          st_nxt = ST_IDLE; // [RQ13]
        end else if (sclk_fall) begin
          if (frame_wrap) begin
            fall_cnt_nxt = {{(`SADC_CNT_W-1){1'b0}}, 1'b1}; // [RQ5] [RQ1]
            bit_nxt      = 1'b0;
          end else begin
            fall_cnt_nxt = fall_cnt_r + {{(`SADC_CNT_W-1){1'b0}}, 1'b1};
            if (fall_cnt_nxt == `SADC_LEAD_ZEROS) begin
              cap_nxt = 1'b1; // [RQ7] [RQ8]
              bit_nxt = 1'b0;
            end else if (fall_cnt_nxt > `SADC_LEAD_ZEROS) begin
              // One trial bit per edge, read from the sample of this conversion.
              bit_nxt = tap_bit; // [RQ3] [RQ4] [RQ9] [RQ10]
              sar_nxt = {sar_r[10:0], bit_nxt};
              if (fall_cnt_nxt == `SADC_FRAME_LEN) begin
                done_nxt = 1'b1; // [RQ1]
              end
            end else begin
              bit_nxt = 1'b0; // [RQ10]
            end
          end
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // Enable and power state follow the synchronised frame select alone, so a frame
  // select that rises mid-conversion floats the line within three core_clk cycles.
  always @* begin
    oe_nxt  = frame_on; // [RQ11]
    pd_nxt  = ~frame_on; // [RQ11]
    acq_nxt = frame_on & lead_phase; // [RQ7]
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r       <= ST_IDLE;
      fall_cnt_r <= {`SADC_CNT_W{1'b0}};
      sar_r      <= 12'h000;
      cap_r      <= 1'b0;
      dout_o     <= 1'b0;
      dout_oe    <= 1'b0;
      power_down <= 1'b1;
      acquiring  <= 1'b0;
      conv_done  <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      fall_cnt_r <= fall_cnt_nxt;
      sar_r      <= sar_nxt;
      cap_r      <= cap_nxt;
      dout_o     <= bit_nxt; // [RQ12]
      dout_oe    <= oe_nxt; // [RQ11]
      power_down <= pd_nxt; // [RQ11]
      acquiring  <= acq_nxt; // [RQ7]
      conv_done  <= done_nxt;
    end
  end
endmodule // sadc_serial_readout

//--- dv/sadc_serial_readout_properties.sv
// Port checker of the serial readout block.
// Assumes a bind onto sadc_serial_readout.
`timescale 1ns/1ns
module sadc_props (
  input wire core_clk,
  input wire sys_rst,
  input wire frame_sel_n,
  input wire sclk,
  input wire dout_o,
  input wire dout_oe,
  input wire power_down,
  input wire acquiring,
  input wire conv_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_idle_float: assert property (frame_sel_n [*5] |-> !dout_oe && power_down)
    else $error("idle drive");
  chk_frame_drive: assert property (!frame_sel_n [*5] |-> dout_oe && !power_down)
    else $error("frame float");
  chk_done_gap: assert property (conv_done |=> !conv_done [*8])
    else $error("done gap");
  chk_done_driven: assert property (conv_done |-> dout_oe)
    else $error("done idle");
  chk_acq_begin: assert property ($fell(power_down) |-> acquiring)
    else $error("no acquire");
  chk_acq_idle: assert property (power_down |-> !acquiring)
    else $error("acquire idle");
  chk_lead_zero: assert property ($fell(acquiring) && dout_oe |-> !dout_o)
    else $error("lead bit");
  chk_bit_fall: assert property ($changed(dout_o) && dout_oe && $past(dout_oe) |-> !sclk)
    else $error("bit edge");
endmodule // sadc_props
bind sadc_serial_readout sadc_props chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .frame_sel_n(frame_sel_n), .sclk(sclk), .dout_o(dout_o), .dout_oe(dout_oe),
  .power_down(power_down), .acquiring(acquiring), .conv_done(conv_done));

//--- dv/sadc_host.sv
// Host model: frames, clocks at 160 ns and captures on rising edges.
// Assumes a 4 ns core_clk; the serial clock stands still between frames.
`timescale 1ns/1ns
module sadc_host (
  input  wire core_clk,
  input  wire dout_o,
  input  wire dout_oe,
  output reg  frame_sel_n,
  output reg  sclk
);
  initial begin
    frame_sel_n = 1'b1;
    sclk = 1'b1;
  end
  task run(input integer falls, output logic [31:0] bits);
    integer i;
    begin
      bits = 32'h00000000;
      frame_sel_n <= 1'b0;
      repeat (20) @(posedge core_clk);
      for (i = 0; i < falls; i = i + 1) begin
        sclk <= 1'b0;
        repeat (20) @(posedge core_clk);
        // A floating line reads as the inverse of the last bit.
        bits = {bits[30:0], dout_oe ? dout_o : ~bits[0]};
        sclk <= 1'b1;
        repeat (20) @(posedge core_clk);
      end
      frame_sel_n <= 1'b1;
      repeat (40) @(posedge core_clk);
    end
  endtask
endmodule // sadc_host

//--- dv/sadc_serial_readout_test.sv
// Self-checking bench of the serial readout block.
// Assumes the host model owns frame select and the serial clock.
`timescale 1ns/1ns
`include "sadc_defs.vh"
`define SADC_CHK(n, e, s) begin comparisons = comparisons + 1; if ((s) !== (e)) begin \
  error_cnt = error_cnt + 1; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module sadc_serial_readout_test;
  reg         core_clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [11:0] ain_code = 12'h000;
  reg  [47:0] codes = {`SADC_POS_FULL, `SADC_NEG_FULL, `SADC_MID_CODE, 12'hfff};
  reg  [31:0] b;
  integer     error_cnt = 0;
  integer     comparisons = 0;
  integer     k;
  wire        frame_sel_n, sclk, dout_o, dout_oe, power_down, acquiring, conv_done;
  sadc_serial_readout dut (.core_clk(core_clk), .sys_rst(sys_rst), .frame_sel_n(frame_sel_n),
    .sclk(sclk), .ain_code(ain_code), .dout_o(dout_o), .dout_oe(dout_oe),
    .power_down(power_down), .acquiring(acquiring), .conv_done(conv_done));
  sadc_host host (.core_clk(core_clk), .dout_o(dout_o), .dout_oe(dout_oe),
    .frame_sel_n(frame_sel_n), .sclk(sclk));
  task t_codes;
    for (k = 0; k < 4; k = k + 1) begin
      ain_code <= codes[k*12 +: 12];
      host.run(16, b);
      `SADC_CHK("frame", {4'h0, codes[k*12 +: 12]}, b[15:0])
    end
  endtask
  task t_back;
    begin
      ain_code <= 12'h5a3;
      fork
        host.run(32, b);
        begin
          // Lands after the first sample and before the second.
          repeat (300) @(posedge core_clk);
          ain_code <= 12'ha5c;
        end
      join
      `SADC_CHK("back", {4'h0, 12'h5a3, 4'h0, 12'ha5c}, b)
    end
  endtask
  task t_abort;
    begin
      ain_code <= 12'h3c1;
      host.run(8, b);
      `SADC_CHK("short", 8'h03, b[7:0])
      `SADC_CHK("float", 1'b0, dout_oe)
      `SADC_CHK("sleep", 1'b1, power_down)
      host.run(16, b);
      `SADC_CHK("again", {4'h0, 12'h3c1}, b[15:0])
    end
  endtask
  task t_status;
    integer n;
    begin
      n = 0;
      ain_code <= 12'h1e7;
      fork
        host.run(16, b);
        begin
          repeat (60) @(posedge core_clk);
          `SADC_CHK("acq", 1'b1, acquiring)
          repeat (140) @(posedge core_clk);
          `SADC_CHK("conv", 1'b0, acquiring)
          repeat (500) @(posedge core_clk) if (conv_done === 1'b1) n = n + 1;
        end
      join
      `SADC_CHK("done", 1, n)
      `SADC_CHK("value", {4'h0, 12'h1e7}, b[15:0])
    end
  endtask
  task final_report;
    begin
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial forever #2 core_clk = ~core_clk;
  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_codes;
    t_back;
    t_abort;
    t_status;
    final_report;
  end
endmodule // sadc_serial_readout_test
